// file: ssbw_pkg.sv
`default_nettype none
package ssbw_pkg;
   localparam int LANE_BITS  = 8;
   localparam int LANES_WIDE = 4;
   localparam int LANES_NARR = 2;
   localparam int LANES      = LANES_WIDE;
   localparam int DATA_BITS  = LANES * LANE_BITS;
   localparam logic [LANES-1:0] LANES_NONE = 4'h0;
   localparam logic [LANES-1:0] LANES_ALL  = 4'hF;
   localparam logic [LANES-1:0] SEL_N_IDLE = 4'hF;

   typedef enum logic [1:0] {
      SSBW_IDLE,
      SSBW_PROC,
      SSBW_WRITE
   } ssbw_state_e;

   typedef struct packed {
      ssbw_state_e      state;
      logic             wr_active;
      logic [LANES-1:0] lane_wr;
      logic             selected;
   } ssbw_state_s;
endpackage
`default_nettype wire

// file: ssbw_lane_drv.sv
`default_nettype none
// per-lane output enable for data and parity; purely combinational
module ssbw_lane_drv (
   input  wire logic                        oe_n,
   input  wire logic                        selected,
   input  wire logic                        wr_active,
   output logic [ssbw_pkg::LANE_BITS-1:0] data_oe,
   output logic                            parity_oe
);
   logic drive;
   // oe acts without a clock, masked while writing
   assign drive = selected & ~oe_n & ~wr_active;
   assign data_oe = {ssbw_pkg::LANE_BITS{drive}};
   assign parity_oe = drive;
endmodule
`default_nettype wire

// file: ssbw_ctrl.sv
`default_nettype none
// How it works
// - processor strobe start is always a read
// - writes only after proc start or controller start
// - output enable ignored during a write
// - output enable gates drivers without clock
// - drivers forced off during write cycles
// - read: tristate when disabled or deselected
// - read: drive all bits when selected, enabled
// - any select combination writes low lanes
// - byte select covers lane data and parity
// - wide variant has four byte lanes
// - global write low writes all lanes
// - write when global write, or lane write with any select low, asserted
// - unselected lanes keep contents in byte write
module ssbw_ctrl (
   input  wire logic                             clk,
   input  wire logic                             rst,
   input  wire logic                             ce,
   input  wire logic                             chip_sel,
   input  wire logic                             proc_addr_strobe_n,
   input  wire logic                             ctrl_addr_strobe_n,
   input  wire logic                             global_write_n,
   input  wire logic                             lane_write_en_n,
   input  wire logic [ssbw_pkg::LANES-1:0]       lane_select_n,
   input  wire logic                             oe_n,
   output logic [ssbw_pkg::LANES-1:0]            lane_wr_reg,
   output logic                                  wr_active_reg,
   output logic                                  selected_reg,
   output logic [ssbw_pkg::DATA_BITS-1:0]        data_io_oe,
   output logic [ssbw_pkg::LANES-1:0]            parity_lane_io_oe
);
   ssbw_pkg::ssbw_state_s st_reg;
   ssbw_pkg::ssbw_state_s st_next;
   logic                  wr_req;
   logic [ssbw_pkg::LANES-1:0] lanes_req;

   function automatic logic [ssbw_pkg::LANES-1:0] lane_decode(
      input logic                         gw_n,
      input logic                         bwe_n,
      input logic [ssbw_pkg::LANES-1:0]   sel_n);
      if (!gw_n)
         lane_decode = ssbw_pkg::LANES_ALL;
      else if (!bwe_n)
         lane_decode = ~sel_n;
      else
         lane_decode = ssbw_pkg::LANES_NONE;
   endfunction

   always_comb begin
      lanes_req = lane_decode(global_write_n, lane_write_en_n,
                              lane_select_n);
      wr_req = (lanes_req != ssbw_pkg::LANES_NONE);
   end

   always_comb begin
      st_next = st_reg;
      st_next.wr_active = 1'b0;
      st_next.lane_wr = ssbw_pkg::LANES_NONE;
      if (!proc_addr_strobe_n) begin
         // proc start reads regardless of write inputs
         st_next.selected = chip_sel;
         st_next.state = chip_sel ? ssbw_pkg::SSBW_PROC
                                  : ssbw_pkg::SSBW_IDLE;
      end else if (!ctrl_addr_strobe_n) begin
         st_next.selected = chip_sel;
         if (chip_sel && wr_req) begin
            st_next.state = ssbw_pkg::SSBW_WRITE;
            st_next.wr_active = 1'b1;
            st_next.lane_wr = lanes_req;
         end else begin
            st_next.state = chip_sel ? ssbw_pkg::SSBW_PROC
                                     : ssbw_pkg::SSBW_IDLE;
         end
      end else begin
         case (st_reg.state)
            ssbw_pkg::SSBW_PROC,
            ssbw_pkg::SSBW_WRITE: begin
               if (wr_req) begin
                  st_next.state = ssbw_pkg::SSBW_WRITE;
                  st_next.wr_active = 1'b1;
                  st_next.lane_wr = lanes_req;
               end else begin
                  st_next.state = ssbw_pkg::SSBW_PROC;
               end
            end
            ssbw_pkg::SSBW_IDLE: begin
               st_next.state = ssbw_pkg::SSBW_IDLE;
            end
            default: begin
               st_next.state = ssbw_pkg::SSBW_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg.state     <= ssbw_pkg::SSBW_IDLE;
         st_reg.wr_active <= 1'b0;
         st_reg.lane_wr   <= ssbw_pkg::LANES_NONE;
         st_reg.selected  <= 1'b0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign lane_wr_reg   = st_reg.lane_wr;
   assign wr_active_reg = st_reg.wr_active;
   assign selected_reg  = st_reg.selected;

   // output enables follow oe_n asynchronously; oe_n ignored while writing
   genvar g;
   generate
      for (g = 0; g < ssbw_pkg::LANES; g = g + 1) begin : g_lane
         ssbw_lane_drv u_drv (
            .oe_n      (oe_n),
            .selected  (st_reg.selected),
            .wr_active (st_reg.wr_active),
            .data_oe   (data_io_oe[g*ssbw_pkg::LANE_BITS +:
                                   ssbw_pkg::LANE_BITS]),
            .parity_oe (parity_lane_io_oe[g])
         );
         a_lane_pair: assert property (@(posedge clk)
            disable iff (rst)
            data_io_oe[g*ssbw_pkg::LANE_BITS +: ssbw_pkg::LANE_BITS]
            == {ssbw_pkg::LANE_BITS{parity_lane_io_oe[g]}})
            else $error("lane data and parity enables split");
      end
   endgenerate

   // start decode and write gating
   a_proc_read: assert property (@(posedge clk) disable iff (rst)
      (ce && !proc_addr_strobe_n) |=> !wr_active_reg)
      else $error("write after processor strobe start");
   a_proc_keep: assert property (@(posedge clk) disable iff (rst)
      (ce && !proc_addr_strobe_n) |=> lane_wr_reg == ssbw_pkg::LANES_NONE)
      else $error("lanes written after processor strobe start");
   a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
      (ce && proc_addr_strobe_n && !ctrl_addr_strobe_n && chip_sel
       && !global_write_n)
      |=> (wr_active_reg && lane_wr_reg == ssbw_pkg::LANES_ALL))
      else $error("controller write not taken");
   a_cont_write: assert property (@(posedge clk) disable iff (rst)
      (ce && proc_addr_strobe_n && ctrl_addr_strobe_n
       && st_reg.state != ssbw_pkg::SSBW_IDLE && !global_write_n)
      |=> (wr_active_reg && lane_wr_reg == ssbw_pkg::LANES_ALL))
      else $error("write after start not taken");
   a_idle_nowr: assert property (@(posedge clk) disable iff (rst)
      (ce && proc_addr_strobe_n && ctrl_addr_strobe_n
       && st_reg.state == ssbw_pkg::SSBW_IDLE) |=> !wr_active_reg)
      else $error("write without start");
   a_global_all: assert property (@(posedge clk) disable iff (rst)
      ($rose(wr_active_reg) && !$past(global_write_n)) |->
      lane_wr_reg == ssbw_pkg::LANES_ALL)
      else $error("global write missed lanes");
   a_lane_exact: assert property (@(posedge clk) disable iff (rst)
      (ce && proc_addr_strobe_n && !ctrl_addr_strobe_n && chip_sel
       && global_write_n && !lane_write_en_n
       && lane_select_n != ssbw_pkg::SEL_N_IDLE)
      |=> lane_wr_reg == ~$past(lane_select_n))
      else $error("lane write mismatch");
   a_lane_keep: assert property (@(posedge clk) disable iff (rst)
      (ce && global_write_n) |=>
      (lane_wr_reg & $past(lane_select_n)) == ssbw_pkg::LANES_NONE)
      else $error("unselected lane written");
   a_wr_lanes: assert property (@(posedge clk) disable iff (rst)
      wr_active_reg == (lane_wr_reg != ssbw_pkg::LANES_NONE))
      else $error("write flag and lanes disagree");
   a_read_only: assert property (@(posedge clk) disable iff (rst)
      (ce && global_write_n && lane_write_en_n) |=> !wr_active_reg)
      else $error("write with no write inputs");
   a_sel_none: assert property (@(posedge clk) disable iff (rst)
      (ce && global_write_n && lane_select_n == ssbw_pkg::SEL_N_IDLE)
      |=> !wr_active_reg)
      else $error("write with no lane selected");
   a_ctrl_read: assert property (@(posedge clk) disable iff (rst)
      (ce && proc_addr_strobe_n && !ctrl_addr_strobe_n && chip_sel
       && global_write_n && lane_write_en_n)
      |=> (selected_reg && !wr_active_reg))
      else $error("controller read not taken");

   // selection and driver enables
   a_proc_desel: assert property (@(posedge clk) disable iff (rst)
      (ce && !proc_addr_strobe_n && !chip_sel)
      |=> (!selected_reg && data_io_oe == '0))
      else $error("processor strobe deselect ignored");
   a_ctrl_desel: assert property (@(posedge clk) disable iff (rst)
      (ce && proc_addr_strobe_n && !ctrl_addr_strobe_n && !chip_sel)
      |=> (!selected_reg && !wr_active_reg))
      else $error("controller strobe deselect ignored");
   a_sel_hold: assert property (@(posedge clk) disable iff (rst)
      (!ce || (proc_addr_strobe_n && ctrl_addr_strobe_n))
      |=> $stable(selected_reg))
      else $error("selection changed without strobe");
   a_sel_state: assert property (@(posedge clk) disable iff (rst)
      selected_reg == (st_reg.state != ssbw_pkg::SSBW_IDLE))
      else $error("selection and state disagree");
   a_wr_mask: assert property (@(posedge clk) disable iff (rst)
      wr_active_reg |-> (data_io_oe == '0 && parity_lane_io_oe == '0))
      else $error("drivers on during write");
   a_oe_ignored: assert property (@(posedge clk) disable iff (rst)
      (wr_active_reg && !oe_n) |-> parity_lane_io_oe == '0)
      else $error("output enable honoured during write");
   a_desel_off: assert property (@(posedge clk) disable iff (rst)
      (!selected_reg || oe_n) |->
      (data_io_oe == '0 && parity_lane_io_oe == '0))
      else $error("driving while disabled");
   a_read_drive: assert property (@(posedge clk) disable iff (rst)
      (selected_reg && !oe_n && !wr_active_reg) |->
      (&data_io_oe && &parity_lane_io_oe))
      else $error("read not driven");

   // scenario covers
   c_proc_then_write: cover property (@(posedge clk) disable iff (rst)
      (ce && chip_sel && !proc_addr_strobe_n) ##2 wr_active_reg);
   c_ctrl_write: cover property (@(posedge clk) disable iff (rst)
      $rose(wr_active_reg));
   c_partial: cover property (@(posedge clk) disable iff (rst)
      wr_active_reg && lane_wr_reg != ssbw_pkg::LANES_ALL);
   c_cont_write: cover property (@(posedge clk) disable iff (rst)
      wr_active_reg && $past(wr_active_reg));
   c_read_drive: cover property (@(posedge clk) disable iff (rst)
      &parity_lane_io_oe);
endmodule
`default_nettype wire

// file: ssbw_host_model.sv
`default_nettype none
module ssbw_host_model (
   input  wire logic [1:0]                 cmd,
   input  wire logic                       gw_n_req,
   input  wire logic                       bwe_n_req,
   input  wire logic [ssbw_pkg::LANES-1:0] sel_n_req,
   input  wire logic                       oe_n_req,
   output logic                            proc_addr_strobe_n,
   output logic                            ctrl_addr_strobe_n,
   output logic                            global_write_n,
   output logic                            lane_write_en_n,
   output logic [ssbw_pkg::LANES-1:0]      lane_select_n,
   output logic                            oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb begin
      proc_addr_strobe_n = cmd != 2'h1;
      ctrl_addr_strobe_n = cmd != 2'h2;
      global_write_n     = gw_n_req;
      lane_write_en_n    = bwe_n_req;
      lane_select_n      = sel_n_req;
      // drivers off before write data is presented
      oe_n = oe_n_req | ((cmd != 2'h1)
             & ~(gw_n_req & (bwe_n_req | &sel_n_req)));
   end
endmodule
`default_nettype wire

// file: sync_sram_byte_write_oe_ctrl_tb_top.sv
`default_nettype none
module sync_sram_byte_write_oe_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0, rst = 1'b1, ce = 1'b1, cs = 1'b0;
   logic [1:0] cmd = 2'h0;
   logic       gw_q = 1'b1, bwe_q = 1'b1, oe_q = 1'b1;
   logic [3:0] sel_q = 4'hF;
   logic       p_n, c_n, gw_n, bwe_n, oe_n, wr_act, sel_r;
   logic [3:0] sel_n, lane_wr, par_oe;
   logic [31:0] d_oe;
   int         fails = 0, tests_run = 0, cyc = 0;
   int         m_start = 0, m_wr = 0, m_sel = 0, m_lanes = 0;
   int         exp_q[$];
   always #10 clk = ~clk;
   ssbw_host_model host (.cmd(cmd), .gw_n_req(gw_q), .bwe_n_req(bwe_q),
      .sel_n_req(sel_q), .oe_n_req(oe_q), .proc_addr_strobe_n(p_n),
      .ctrl_addr_strobe_n(c_n), .global_write_n(gw_n),
      .lane_write_en_n(bwe_n), .lane_select_n(sel_n), .oe_n(oe_n));
   ssbw_ctrl dut (.clk(clk), .rst(rst), .ce(ce), .chip_sel(cs),
      .proc_addr_strobe_n(p_n), .ctrl_addr_strobe_n(c_n),
      .global_write_n(gw_n), .lane_write_en_n(bwe_n),
      .lane_select_n(sel_n), .oe_n(oe_n), .lane_wr_reg(lane_wr),
      .wr_active_reg(wr_act), .selected_reg(sel_r), .data_io_oe(d_oe),
      .parity_lane_io_oe(par_oe));
   task automatic report_and_stop;
      $display("tests_run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (exp !== got) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step(logic [1:0] c, logic s, logic g, logic b,
                       logic [3:0] l, logic o, logic e);
      logic        w;
      logic [31:0] oe;
      @(posedge clk);
      w = !gw_n | (!bwe_n & (sel_n != 4'hF));
      if (rst) begin
         m_start = 0;
         m_wr = 0;
         m_sel = 0;
         m_lanes = 0;
      end else if (ce) begin
         m_wr = 0;
         if (!p_n | !c_n) begin
            m_start = cs;
            m_sel = cs;
         end
         if (p_n)
            m_wr = m_start & w;
         m_lanes = !m_wr ? 0 : !gw_n ? 15 : 4'hF ^ sel_n;
      end
      exp_q.push_back(m_lanes);
      cmd <= c;
      cs <= s;
      gw_q <= g;
      bwe_q <= b;
      sel_q <= l;
      oe_q <= o;
      ce <= e;
      @(negedge clk);
      oe = (m_sel != 0 && m_wr == 0 && !oe_n) ? '1 : '0;
      check("lane_wr", exp_q.pop_front(), lane_wr);
      check("wr_active", m_wr, wr_act);
      check("selected", m_sel, sel_r);
      check("data_oe", oe, d_oe);
      check("parity_oe", oe[3:0], par_oe);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 19)
         rst <= 1'b0;
      if (cyc == 1000) begin
         fails++;
         report_and_stop;
      end
   end
   initial begin
      logic [31:0] r;
      logic [1:0]  c;
      void'($urandom(32'hEC58));
      repeat (21) step(0, 0, 1, 1, 4'hF, 1, 1);
      step(1, 1, 0, 0, 4'h0, 0, 1);
      step(0, 1, 0, 1, 4'hF, 1, 1);
      step(0, 1, 1, 1, 4'hF, 0, 1);
      step(0, 1, 1, 1, 4'hF, 0, 1);
      for (int i = 0; i < 16; i++)
         step(2, 1, 1, 0, 4'(i), 1, 1);
      step(2, 0, 0, 1, 4'hF, 0, 1);
      step(0, 0, 1, 1, 4'hF, 0, 1);
      $display("test directed done");
      for (int i = 0; i < 400; i++) begin
         r = $urandom;
         c = r[1:0] == 2'h1 ? 2'h1 : r[2] ? 2'h2 : 2'h0;
         // write inputs also follow idle strobes: continued and byte writes
         step(c, r[3] | r[4], r[5] | r[6], r[7], r[11:8], r[12],
              r[13] | r[14]);
      end
      $display("test random done");
      report_and_stop;
   end
endmodule
`default_nettype wire
